/* rtl/eebp_pkg.sv */
// Purpose: Shared constants and types for the EEPROM block-protect checker
// Assumes: 32-bit classic Wishbone register access, word-aligned registers
// Notes:   Array and region bounds are absolute 16-bit CPU addresses
package eebp_pkg;

  // ********************************************************
  // Array geometry
  // ********************************************************
  localparam logic [15:0] ARRAY_BASE   = 16'h0800;
  localparam logic [15:0] ARRAY_LAST   = 16'h09ff;
  localparam logic [15:0] SECURE_FIRST = 16'h08f0;
  localparam logic [15:0] SECURE_LAST  = 16'h08ff;
  localparam int          BLOCK_LSB    = 7;
  localparam int          NUM_BLOCKS   = 4;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] REQ_OFS  = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;

  // Control register fields
  localparam int         CTRL_PROT_LSB = 0;
  localparam int         CTRL_SEC_BIT  = 4;
  localparam logic [3:0] PROT_RESET    = 4'hf;
  localparam logic       SEC_RESET     = 1'h0;

  // Request register fields
  localparam int REQ_ADDR_LSB = 0;
  localparam int REQ_OP_LSB   = 16;

  // Status register fields
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_GRANT_BIT  = 1;
  localparam int STAT_DENY_LSB   = 8;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    OP_BYTE_PROG  = 2'h0,
    OP_BYTE_ERASE = 2'h1,
    OP_BLOCK_ERASE = 2'h2,
    OP_BULK_ERASE = 2'h3
  } eebp_op_t;

  typedef struct packed {
    eebp_op_t    op;
    logic [15:0] addr;
  } eebp_req_t;

endpackage

/* rtl/eebp_blk_chk.sv */
// Purpose: Permission check for one 128-byte block of the array
// Assumes: Caller decodes which block and whether the secured window is hit
// Notes:   Purely combinational; the top registers every result
`timescale 1ns/1ps
module eebp_blk_chk (
  input  wire logic block_protect_bit_n_i,
  input  wire logic array_security_bit_i,
  input  wire logic secure_hit_i,
  output logic      byte_ok_o,
  output logic      erase_wide_ok_o
);

  // Byte program and byte erase: protect bit wins, then the secured window
  assign byte_ok_o = !block_protect_bit_n_i &&
                     !(!array_security_bit_i && secure_hit_i);

  // Block and bulk erase need the security bit set
  assign erase_wide_ok_o = !block_protect_bit_n_i &&
                           array_security_bit_i;

endmodule // eebp_blk_chk

/* rtl/eeprom_block_protect.sv */
// Purpose: Grants or refuses EEPROM program/erase requests by protection
// Assumes: Single clock, requests arrive as writes to the request register
// Notes:   Only a granted request ever raises the high-voltage start pulse
`timescale 1ns/1ps

// Function
// - Protect bit 1 blocks program/erase; bit 0 permits, subject to security.
// - Protect bits 0..3 cover 0800-087F, 0880-08FF, 0900-097F, 0980-09FF.
// - Security 1, open block: program and block/byte erase allowed; bulk erase needs all four blocks open.
// - Security 0, open block: only byte program and byte erase allowed.
// - Security 0: nothing programmed or erased in 08F0-08FF, any protect bit.
// - Protected block refuses everything, whatever the security bit.
module eeprom_block_protect (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             hv_start_o,
  output eebp_pkg::eebp_req_t hv_req_o,
  output logic             req_refused_o,
  output logic [3:0]       block_protect_bits_o,
  output logic             array_security_bit_o
);

  // ********************************************************
  // State
  // ********************************************************
  logic                [31:0] dat_r, dat_nxt;
  logic                       ack_r, ack_nxt;
  logic                [3:0]  prot_r, prot_nxt;
  logic                       sec_r, sec_nxt;
  eebp_pkg::eebp_req_t        req_r, req_nxt;
  eebp_pkg::eebp_req_t        hv_r, hv_nxt;
  logic                       start_r, start_nxt;
  logic                       deny_r, deny_nxt;
  logic                       done_r, done_nxt;
  logic                       grant_r, grant_nxt;
  logic                [7:0]  deny_cnt_r, deny_cnt_nxt;

  // ********************************************************
  // Request decode
  // ********************************************************
  logic                access;
  logic                req_wr;
  eebp_pkg::eebp_req_t new_req;
  logic                in_array;
  logic                secure_hit;
  logic [1:0]          blk_idx;
  logic [3:0]          byte_ok;
  logic [3:0]          wide_ok;
  logic                allowed;

  assign access = wb_cyc_i && wb_stb_i && !ack_r;
  assign req_wr = access && wb_we_i && (wb_adr_i == eebp_pkg::REQ_OFS);

  // Lanes not selected keep the previous request fields
  always_comb begin
    new_req = req_r;
    if (wb_sel_i[0]) begin
      new_req.addr[7:0] = wb_dat_i[eebp_pkg::REQ_ADDR_LSB +: 8];
    end
    if (wb_sel_i[1]) begin
      new_req.addr[15:8] = wb_dat_i[eebp_pkg::REQ_ADDR_LSB + 8 +: 8];
    end
    if (wb_sel_i[2]) begin
      new_req.op = eebp_pkg::eebp_op_t'(wb_dat_i[eebp_pkg::REQ_OP_LSB +: 2]);
    end
  end

  // Decode the merged request so a partial write is judged on the
  // address that will actually be stored
  assign in_array = (new_req.addr >= eebp_pkg::ARRAY_BASE) &&
                    (new_req.addr <= eebp_pkg::ARRAY_LAST);
  assign secure_hit = (new_req.addr >= eebp_pkg::SECURE_FIRST) &&
                      (new_req.addr <= eebp_pkg::SECURE_LAST);
  assign blk_idx = new_req.addr[eebp_pkg::BLOCK_LSB +: 2];

  // ********************************************************
  // Per-block permission
  // ********************************************************
  // One checker per block keeps the protect and security logic in one
  // place; the decoded block index picks which result counts
  genvar g;
  generate
    for (g = 0; g < eebp_pkg::NUM_BLOCKS; g++) begin : g_blk
      eebp_blk_chk u_chk (
        .block_protect_bit_n_i (prot_r[g]),
        .array_security_bit_i  (sec_r),
        .secure_hit_i          (secure_hit),
        .byte_ok_o             (byte_ok[g]),
        .erase_wide_ok_o       (wide_ok[g])
      );
    end
  endgenerate

  // Bulk erase sweeps all four blocks, so every block must allow it
  always_comb begin
    allowed = 1'b0;
    case (new_req.op)
      eebp_pkg::OP_BYTE_PROG,
      eebp_pkg::OP_BYTE_ERASE: begin
        allowed = in_array && byte_ok[blk_idx];
      end
      eebp_pkg::OP_BLOCK_ERASE: begin
        allowed = in_array && wide_ok[blk_idx];
      end
      eebp_pkg::OP_BULK_ERASE: begin
        allowed = &wide_ok;
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    ack_nxt      = access;
    dat_nxt      = 32'h0000_0000;
    prot_nxt     = prot_r;
    sec_nxt      = sec_r;
    req_nxt      = req_r;
    hv_nxt       = hv_r;
    start_nxt    = 1'b0;
    deny_nxt     = 1'b0;
    done_nxt     = done_r;
    grant_nxt    = grant_r;
    deny_cnt_nxt = deny_cnt_r;
    // Control bits all sit in lane 0; without it the write is ignored
    if (access && wb_we_i && (wb_adr_i == eebp_pkg::CTRL_OFS) &&
        wb_sel_i[0]) begin
      prot_nxt = wb_dat_i[eebp_pkg::CTRL_PROT_LSB +: 4];
      sec_nxt  = wb_dat_i[eebp_pkg::CTRL_SEC_BIT];
    end
    if (req_wr) begin
      req_nxt   = new_req;
      done_nxt  = 1'b1;
      grant_nxt = allowed;
      if (allowed) begin
        hv_nxt    = new_req;
        start_nxt = 1'b1;
      end else begin
        // Refusal never touches the high-voltage outputs
        deny_nxt     = 1'b1;
        // Counter wraps at 8 bits; software reads differences
        deny_cnt_nxt = deny_cnt_r + 8'h01;
      end
    end
    // Read data is registered so that it stands exactly with ack
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        eebp_pkg::CTRL_OFS: begin
          dat_nxt[eebp_pkg::CTRL_PROT_LSB +: 4] = prot_r;
          dat_nxt[eebp_pkg::CTRL_SEC_BIT]       = sec_r;
        end
        eebp_pkg::REQ_OFS: begin
          dat_nxt[eebp_pkg::REQ_ADDR_LSB +: 16] = req_r.addr;
          dat_nxt[eebp_pkg::REQ_OP_LSB +: 2]    = req_r.op;
        end
        eebp_pkg::STAT_OFS: begin
          dat_nxt[eebp_pkg::STAT_DONE_BIT]     = done_r;
          dat_nxt[eebp_pkg::STAT_GRANT_BIT]    = grant_r;
          dat_nxt[eebp_pkg::STAT_DENY_LSB +: 8] = deny_cnt_r;
        end
        default: begin
          dat_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  // Reset leaves every block locked and security clear, the safe state
  // until software opens the array on purpose
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r      <= 1'b0;
      dat_r      <= 32'h0000_0000;
      prot_r     <= eebp_pkg::PROT_RESET;
      sec_r      <= eebp_pkg::SEC_RESET;
      req_r      <= '0;
      hv_r       <= '0;
      start_r    <= 1'b0;
      deny_r     <= 1'b0;
      done_r     <= 1'b0;
      grant_r    <= 1'b0;
      deny_cnt_r <= 8'h00;
    end else begin
      ack_r      <= ack_nxt;
      dat_r      <= dat_nxt;
      prot_r     <= prot_nxt;
      sec_r      <= sec_nxt;
      req_r      <= req_nxt;
      hv_r       <= hv_nxt;
      start_r    <= start_nxt;
      deny_r     <= deny_nxt;
      done_r     <= done_nxt;
      grant_r    <= grant_nxt;
      deny_cnt_r <= deny_cnt_nxt;
    end
  end

  // Every output is a register copy; no decode reaches a pin
  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = dat_r;
  assign hv_start_o           = start_r;
  assign hv_req_o             = hv_r;
  assign req_refused_o        = deny_r;
  assign block_protect_bits_o = prot_r;
  assign array_security_bit_o = sec_r;

endmodule // eeprom_block_protect

/* verif/eebp_monitor.sv */
// Purpose: Bus timing and permission checks on the protect block
// Assumes: One clock domain, async active-high reset
// Notes:   prot_d/sec_d hold the settings that stood at the taking edge
`timescale 1ns/1ps
module eebp_monitor (
  input wire logic                sys_clk_i,
  input wire logic                reset_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [3:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  input wire logic                hv_start_o,
  input wire eebp_pkg::eebp_req_t hv_req_o,
  input wire logic                req_refused_o,
  input wire logic [3:0]          block_protect_bits_o,
  input wire logic                array_security_bit_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  logic       take, rq, inr, sec_d;
  logic [3:0] prot_d;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rq = take && wb_we_i && wb_adr_i == eebp_pkg::REQ_OFS && &wb_sel_i;
  assign inr = wb_dat_i[15:0] >= 16'h0800 && wb_dat_i[15:0] <= 16'h09ff;
  always_ff @(posedge sys_clk_i) begin
    prot_d <= block_protect_bits_o;
    sec_d <= array_security_bit_o;
  end
  property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_one; rq |=> hv_start_o != req_refused_o; endproperty
  a_one: assert property (p_one) else $error("no single result");
  property p_grant;
    rq && array_security_bit_o && inr && wb_dat_i[17:16] != 2'h3
      && !block_protect_bits_o[wb_dat_i[8:7]] |=> hv_start_o;
  endproperty
  a_grant: assert property (p_grant) else $error("open refused");
  property p_prot;
    rq && inr && wb_dat_i[17:16] != 2'h3
      && block_protect_bits_o[wb_dat_i[8:7]] |=> req_refused_o;
  endproperty
  a_prot: assert property (p_prot) else $error("locked granted");
  property p_wide; hv_start_o && !sec_d |-> !hv_req_o.op[1]; endproperty
  a_wide: assert property (p_wide) else $error("wide erase");
  property p_lock;
    hv_start_o && !sec_d |-> hv_req_o.addr[15:4] != 12'h08f;
  endproperty
  a_lock: assert property (p_lock) else $error("secured hit");
  property p_map;
    hv_start_o && hv_req_o.op != eebp_pkg::OP_BULK_ERASE |->
      hv_req_o.addr[15:9] == 7'h04 && !prot_d[hv_req_o.addr[8:7]];
  endproperty
  a_map: assert property (p_map) else $error("block map");
  property p_bulk;
    hv_start_o && hv_req_o.op == eebp_pkg::OP_BULK_ERASE |->
      prot_d == 4'h0 && sec_d;
  endproperty
  a_bulk: assert property (p_bulk) else $error("bulk grant");
  property p_quiet; req_refused_o |-> !hv_start_o && $stable(hv_req_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("refusal moved hv");
endmodule // eebp_monitor

bind eeprom_block_protect eebp_monitor eebp_monitor_i (
  .sys_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .hv_start_o, .hv_req_o,
  .req_refused_o, .block_protect_bits_o, .array_security_bit_o);

/* verif/eebp_hv_model.sv */
// Purpose: High-voltage sequencer stand-in that counts started cycles
// Assumes: Start is a one-cycle pulse
// Notes:   Count lets the bench prove refusals never arm the pump
`timescale 1ns/1ps
module eebp_hv_model (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        hv_start_i,
  output logic      [15:0] starts_o
);
  logic [15:0] starts_r, starts_nxt;
  always_comb starts_nxt = starts_r + 16'(hv_start_i);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) starts_r <= 16'h0000;
    else starts_r <= starts_nxt;
  end
  assign starts_o = starts_r;
endmodule // eebp_hv_model

/* verif/eeprom_block_protect_test.sv */
// Purpose: Self-checking bench for the protect block
// Assumes: One ack per access, pulses in the ack cycle
// Notes:   Grant expectation is rebuilt from the protection rules
`timescale 1ns/1ps
module eeprom_block_protect_test;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'hf, prot, pv;
  logic [31:0] wdat = 32'h0, rdat, got, lastw;
  logic        ack, hvs, refd, sec, g, r, sv, lastg;
  logic [15:0] starts;
  logic [15:0] al[9] = '{16'h0800, 16'h087f, 16'h0880, 16'h08ef, 16'h08f0,
                         16'h08ff, 16'h0900, 16'h09ff, 16'h0a00};
  eebp_pkg::eebp_req_t hreq;
  int          errors = 0, n_checks = 0, ngr = 0, nref = 0;
  always #25 clk = ~clk;
  eeprom_block_protect eeprom_block_protect_i (.sys_clk_i(clk),
    .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hv_start_o(hvs), .hv_req_o(hreq),
    .req_refused_o(refd), .block_protect_bits_o(prot),
    .array_security_bit_o(sec));
  eebp_hv_model eebp_hv_model_i (.sys_clk_i(clk), .reset_i(rst),
    .hv_start_i(hvs), .starts_o(starts));
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_checks++;
    if (a !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    g = hvs;
    r = refd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic ok(input logic [3:0] p, input logic s,
                              input logic [1:0] o, input logic [15:0] a);
    if (o == 2'h3) return s && p == 4'h0;
    if (a < 16'h0800 || a > 16'h09ff || p[a[8:7]]) return 1'b0;
    if (!s && a >= 16'h08f0 && a <= 16'h08ff) return 1'b0;
    return s || !o[1];
  endfunction
  task automatic req(input logic [1:0] o, input logic [15:0] a);
    lastg = ok(pv, sv, o, a);
    lastw = {14'h0, o, a};
    acc(1'b1, eebp_pkg::REQ_OFS, lastw);
    chk({g, r}, {lastg, !lastg});
    if (lastg) begin
      chk(hreq, lastw);
      ngr++;
    end else nref++;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pv = 4'hf;
    sv = 1'b0;
    acc(1'b0, eebp_pkg::CTRL_OFS, 32'h0);
    chk(got, 32'h0000000f);
    req(2'h0, 16'h0800);
    $display("reset test done");
    for (int c = 0; c < 4; c++) begin
      pv = c[0] ? 4'h0 : 4'ha;
      sv = c[1];
      acc(1'b1, eebp_pkg::CTRL_OFS, {27'h0, sv, pv});
      chk({sec, prot}, {sv, pv});
      foreach (al[i])
        for (int o = 0; o < 4; o++)
          req(2'(o), al[i]);
    end
    chk(starts, 16'(ngr));
    $display("permission test done");
    sel <= 4'he;
    acc(1'b1, eebp_pkg::CTRL_OFS, 32'h0000000f);
    sel <= 4'hf;
    chk({sec, prot}, {sv, pv});
    acc(1'b1, 4'hc, 32'hffffffff);
    acc(1'b0, 4'hc, 32'h0);
    chk(got, 32'h0);
    acc(1'b0, eebp_pkg::REQ_OFS, 32'h0);
    chk(got, lastw);
    acc(1'b0, eebp_pkg::STAT_OFS, 32'h0);
    chk(got, {16'h0, 8'(nref), 6'h0, lastg, 1'b1});
    $display("register test done");
    sel <= 4'h3;
    acc(1'b1, eebp_pkg::REQ_OFS, 32'h00000880);
    sel <= 4'hf;
    chk({g, r}, 32'h2);
    acc(1'b0, eebp_pkg::REQ_OFS, 32'h0);
    chk(got, 32'h00030880);
    $display("partial lane test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pv = 4'hf;
    sv = 1'b0;
    chk({starts, sec, prot}, {16'h0, sv, pv});
    acc(1'b0, eebp_pkg::STAT_OFS, 32'h0);
    chk(got, 32'h0);
    req(2'h1, 16'h0980);
    $display("second reset test done");
    complete_run();
  end
endmodule // eeprom_block_protect_test
